// File: common/sysctl_defs.svh
`ifndef SYSCTL_DEFS_SVH
`define SYSCTL_DEFS_SVH
`define OP_RD_REG 16'hD000
`define OP_WR_REG 16'hD040
`define OP_MCLR 16'hD080
`define OP_MSET 16'hD0C0
`define OP_XFER_MASK 16'hFFF0
`define OP_IRQ_OFF 16'hD101
`define OP_IRQ_ON 16'hD102
`define OP_PAGE_OFF 16'hD104
`define OP_WIDE_SET 16'hD106
`define OP_WIDE_CLR 16'hD107
`define OP_PAGE_ON 16'hD108
`define OP_PAGE_IRQ_ON 16'hD10A
`define OP_PAGE_IRQ_OFF 16'hD10B
`define OP_PEEK 16'hD10E
`define OP_POKE 16'hD10F
`define OP_IDENT10 16'hC784
`define OP_IDENT11 16'hC789
`define OP_IDENT12 16'hC792
`define OP_IDENT13 16'hC7A3
`define OP_UCODE_LOAD 16'hC740
`define OP_WAIT 16'hD200
`define OP_WAIT_MASK 16'hFF00
`define REG_REQ_MASK 4'h6
`define REG_EN_MASK 4'h7
`define REG_CODE_LSB 0
`define REG_CODE_MSB 3
`define LVL_IDENT10 4'hA
`define LVL_IDENT11 4'hB
`define LVL_IDENT12 4'hC
`define LVL_IDENT13 4'hD
`define LVL_INTERNAL 4'hE
`define LVL_ZERO 4'h0
`define EXT_REQ_LEVELS 16'hBC00
`define RING_PRIV_LO 2'h2
`define IDENT_CODE_W 9
`define IDENT_PAD 7'h00
`define IDENT_TIMEOUT 4'hF
`define UCODE_BASE 24'h003C00
`define UCODE_ENTRIES 9'h100
`define UCODE_WORD_LAST 2'h3
`define CAUSE_NONE 2'h0
`define CAUSE_PRIV 2'h1
`define CAUSE_IO 2'h2
`endif

// File: common/sysctl_pkg.sv
package sysctl_pkg;
   typedef enum logic [5:0] {
      ST_IDLE = 6'h01,
      ST_IDENT = 6'h02,
      ST_MEM = 6'h04,
      ST_UCODE = 6'h08,
      ST_HALT = 6'h10,
      ST_DONE = 6'h20
   } state_t;
   typedef logic [3:0] level_t;
   typedef logic [1:0] cause_t;
endpackage

// File: rtl/system_control_instruction_unit.sv
`include "sysctl_defs.svh"

module system_control_instruction_unit (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic instrValid,
   input wire logic [15:0] instr,
   input wire logic [15:0] aIn,
   input wire logic [15:0] dIn,
   input wire logic [15:0] tIn,
   input wire logic [1:0] ring,
   input wire logic ioErrIrqEnable,
   input wire logic privIrqEnable,
   input wire logic consoleRestart,
   input wire logic [15:0] extReq,
   input wire logic identAck,
   input wire logic [8:0] identCode,
   input wire logic memAck,
   input wire logic [15:0] memRdata,
   output logic instrReady,
   output logic instrDone,
   output logic [15:0] accOut,
   output logic accWe,
   output logic [15:0] tOut,
   output logic tWe,
   output sysctl_pkg::level_t currentLevel,
   output logic irqSystemOn,
   output logic pagingOn,
   output logic wideAddressing,
   output logic runLamp,
   output logic identReq,
   output sysctl_pkg::level_t identLevel,
   output logic memReq,
   output logic memWe,
   output logic [23:0] memAddr,
   output logic [15:0] memWdata,
   output logic intIrq,
   output sysctl_pkg::cause_t intIrqCause,
   output logic ucodeLoaded
);
   import sysctl_pkg::*;

   state_t state_r, state_nxt;
   logic [15:0] enMask_r, reqMask_r;
   level_t level_r;
   logic irqOn_r, pageOn_r, wide_r, run_r;
   logic ready_r, done_r, accWe_r, tWe_r, identReq_r;
   logic [15:0] acc_r, t_r, memWdata_r;
   level_t identLvl_r;
   logic memReq_r, memWe_r;
   logic [23:0] memAddr_r;
   logic intIrq_r;
   cause_t cause_r;
   logic loaded_r;
   logic [3:0] timer_r;
   logic [7:0] ucEntry_r;
   logic [1:0] ucWord_r;
   logic [47:0] ucShift_r;
   logic [63:0] ucodeStore [0:255];

   function automatic level_t topLevel(input logic [15:0] m);
      level_t l;
      l = `LVL_ZERO;
      for (int i = 0; i < 16; i++) begin
         if (m[i]) begin
            l = 4'(i);
         end
      end
      return l;
   endfunction

   wire logic take = instrValid && ready_r && state_r == ST_IDLE;
   wire logic privOk = !pageOn_r || ring >= `RING_PRIV_LO;
   wire logic isXfer = (instr & `OP_XFER_MASK) == `OP_RD_REG
      || (instr & `OP_XFER_MASK) == `OP_WR_REG
      || (instr & `OP_XFER_MASK) == `OP_MCLR
      || (instr & `OP_XFER_MASK) == `OP_MSET;
   wire logic [15:0] xferKind = instr & `OP_XFER_MASK;
   wire logic [3:0] regCode = instr[`REG_CODE_MSB:`REG_CODE_LSB];
   wire logic selEn = regCode == `REG_EN_MASK;
   wire logic selReq = regCode == `REG_REQ_MASK;
   wire logic isIdent = instr == `OP_IDENT10 || instr == `OP_IDENT11
      || instr == `OP_IDENT12 || instr == `OP_IDENT13;
   wire level_t identSel = instr == `OP_IDENT10 ? `LVL_IDENT10 :
      instr == `OP_IDENT11 ? `LVL_IDENT11 :
      instr == `OP_IDENT12 ? `LVL_IDENT12 : `LVL_IDENT13;
   wire logic isWait = (instr & `OP_WAIT_MASK) == `OP_WAIT;
   wire logic isOn = instr == `OP_IRQ_ON || instr == `OP_PAGE_IRQ_ON;
   wire logic isOff = instr == `OP_IRQ_OFF || instr == `OP_PAGE_IRQ_OFF;
   wire logic isPgOn = instr == `OP_PAGE_ON || instr == `OP_PAGE_IRQ_ON;
   wire logic isPgOff = instr == `OP_PAGE_OFF || instr == `OP_PAGE_IRQ_OFF;
   wire logic isPeek = instr == `OP_PEEK;
   wire logic isPoke = instr == `OP_POKE;
   wire logic isUcode = instr == `OP_UCODE_LOAD;
   wire logic isPriv = isXfer || isIdent || isWait || isOn || isOff
      || isPgOn || isPgOff || isPeek || isPoke || isUcode
      || instr == `OP_WIDE_SET || instr == `OP_WIDE_CLR;
   // Paging-off is refused outside rings 3 and 2 even with paging off.
   wire logic ringOk = isPgOff ? ring >= `RING_PRIV_LO : privOk;
   wire logic exec = take && isPriv && ringOk;
   wire logic privFault = take && isPriv && !ringOk;
   wire logic identHit = state_r == ST_IDENT && identAck;
   wire logic identMiss = state_r == ST_IDENT && !identAck
      && timer_r == `IDENT_TIMEOUT;
   wire logic ioFault = identMiss && ioErrIrqEnable;
   wire logic ucLast = state_r == ST_UCODE && memAck
      && ucWord_r == `UCODE_WORD_LAST;

   // Masks fed from the accumulator for the three writing transfer forms (write, clear, set).
   wire logic [15:0] enWr = xferKind == `OP_WR_REG ? aIn :
      xferKind == `OP_MCLR ? (enMask_r & ~aIn) :
      xferKind == `OP_MSET ? (enMask_r | aIn) : enMask_r;
   wire logic [15:0] reqWr = xferKind == `OP_WR_REG ? aIn :
      xferKind == `OP_MCLR ? (reqMask_r & ~aIn) :
      xferKind == `OP_MSET ? (reqMask_r | aIn) : reqMask_r;
   wire logic wrXfer = exec && isXfer && xferKind != `OP_RD_REG;
   wire logic waitGive = exec && isWait && irqOn_r
      && level_r != `LVL_ZERO;
   wire logic [15:0] waitClr = waitGive ? (16'h0001 << level_r) : 16'h0000;
   // External lines are level sensitive and only reach the vectored and
   // fast levels; a request present while software clears its bit wins.
   wire logic [15:0] hwSet = (extReq & `EXT_REQ_LEVELS)
      | ((privFault && privIrqEnable) || ioFault
         ? (16'h0001 << `LVL_INTERNAL) : 16'h0000);
   wire logic [15:0] reqBase = wrXfer && selReq ? reqWr : reqMask_r;
   wire logic [15:0] reqNext = (reqBase & ~waitClr) | hwSet;
   wire logic [15:0] enNext = wrXfer && selEn ? enWr : enMask_r;
   wire logic [15:0] rdVal = selEn ? enMask_r :
      selReq ? reqMask_r : 16'h0000;

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: begin
            if (exec && isIdent) begin
               state_nxt = ST_IDENT;
            end else if (exec && (isPeek || isPoke)) begin
               state_nxt = ST_MEM;
            end else if (exec && isUcode) begin
               state_nxt = ST_UCODE;
            end else if (exec && isWait && !irqOn_r) begin
               state_nxt = ST_HALT;
            end else if (take) begin
               state_nxt = ST_DONE;
            end
         end
         ST_IDENT: if (identHit || identMiss) state_nxt = ST_DONE;
         ST_MEM: if (memAck) state_nxt = ST_DONE;
         ST_UCODE: begin
            if (ucLast && ucEntry_r == 8'(`UCODE_ENTRIES - 9'h001)) begin
               state_nxt = ST_DONE;
            end
         end
         ST_HALT: if (consoleRestart) state_nxt = ST_DONE;
         ST_DONE: state_nxt = ST_IDLE;
         default: state_nxt = ST_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         state_r <= ST_IDLE;
         enMask_r <= 16'h0000;
         reqMask_r <= 16'h0000;
         level_r <= `LVL_ZERO;
      end else begin
         state_r <= state_nxt;
         enMask_r <= enNext;
         reqMask_r <= reqNext;
         // Switching happens only with the system on; off freezes it.
         if (irqOn_r) begin
            level_r <= topLevel(enMask_r & reqMask_r);
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         irqOn_r <= 1'b0;
         pageOn_r <= 1'b0;
         wide_r <= 1'b0;
         run_r <= 1'b1;
      end else begin
         if (exec && isOn) irqOn_r <= 1'b1;
         else if (exec && isOff) irqOn_r <= 1'b0;
         if (exec && isPgOn) pageOn_r <= 1'b1;
         else if (exec && isPgOff) pageOn_r <= 1'b0;
         if (exec && instr == `OP_WIDE_SET) wide_r <= 1'b1;
         else if (exec && instr == `OP_WIDE_CLR) wide_r <= 1'b0;
         run_r <= state_nxt != ST_HALT;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         ready_r <= 1'b0;
         done_r <= 1'b0;
         accWe_r <= 1'b0;
         acc_r <= 16'h0000;
         tWe_r <= 1'b0;
         t_r <= 16'h0000;
         intIrq_r <= 1'b0;
         cause_r <= `CAUSE_NONE;
      end else begin
         ready_r <= state_nxt == ST_IDLE;
         done_r <= state_r == ST_DONE;
         accWe_r <= 1'b0;
         tWe_r <= 1'b0;
         intIrq_r <= 1'b0;
         if (exec && xferKind == `OP_RD_REG && isXfer) begin
            acc_r <= rdVal;
            accWe_r <= 1'b1;
         end
         if (identHit) begin
            acc_r <= {`IDENT_PAD, identCode};
            accWe_r <= 1'b1;
         end
         if (state_r == ST_MEM && memAck && !memWe_r) begin
            t_r <= memRdata;
            tWe_r <= 1'b1;
         end
         if (privFault && privIrqEnable) begin
            intIrq_r <= 1'b1;
            cause_r <= `CAUSE_PRIV;
         end else if (ioFault) begin
            intIrq_r <= 1'b1;
            cause_r <= `CAUSE_IO;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         identReq_r <= 1'b0;
         identLvl_r <= `LVL_ZERO;
         timer_r <= 4'h0;
      end else begin
         if (exec && isIdent) begin
            identReq_r <= 1'b1;
            identLvl_r <= identSel;
            timer_r <= 4'h0;
         end else if (state_r == ST_IDENT) begin
            // A silent bus must not hang the processor.
            timer_r <= timer_r + 4'h1;
            if (identHit || identMiss) identReq_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         memReq_r <= 1'b0;
         memWe_r <= 1'b0;
         memAddr_r <= 24'h000000;
         memWdata_r <= 16'h0000;
         ucEntry_r <= 8'h00;
         ucWord_r <= 2'h0;
         ucShift_r <= 48'h0;
         loaded_r <= 1'b0;
      end else begin
         if (exec && (isPeek || isPoke)) begin
            memReq_r <= 1'b1;
            memWe_r <= isPoke;
            memAddr_r <= {aIn[7:0], dIn};
            memWdata_r <= tIn;
         end else if (exec && isUcode) begin
            memReq_r <= 1'b1;
            memWe_r <= 1'b0;
            memAddr_r <= `UCODE_BASE;
            ucEntry_r <= 8'h00;
            ucWord_r <= 2'h0;
         end else if (state_r == ST_MEM && memAck) begin
            memReq_r <= 1'b0;
         end else if (state_r == ST_UCODE && memAck) begin
            memAddr_r <= memAddr_r + 24'h000001;
            ucWord_r <= ucWord_r + 2'h1;
            ucShift_r <= {ucShift_r[31:0], memRdata};
            if (ucLast) begin
               ucEntry_r <= ucEntry_r + 8'h01;
               if (ucEntry_r == 8'(`UCODE_ENTRIES - 9'h001)) begin
                  memReq_r <= 1'b0;
                  loaded_r <= 1'b1;
               end
            end
         end
      end
   end

   // Four words per entry, first word lands in the top quarter.
   always_ff @(posedge sys_clk) begin
      if (ucLast) begin
         ucodeStore[ucEntry_r] <= {ucShift_r, memRdata};
      end
   end

   assign instrReady = ready_r;
   assign instrDone = done_r;
   assign accOut = acc_r;
   assign accWe = accWe_r;
   assign tOut = t_r;
   assign tWe = tWe_r;
   assign currentLevel = level_r;
   assign irqSystemOn = irqOn_r;
   assign pagingOn = pageOn_r;
   assign wideAddressing = wide_r;
   assign runLamp = run_r;
   assign identReq = identReq_r;
   assign identLevel = identLvl_r;
   assign memReq = memReq_r;
   assign memWe = memWe_r;
   assign memAddr = memAddr_r;
   assign memWdata = memWdata_r;
   assign intIrq = intIrq_r;
   assign intIrqCause = cause_r;
   assign ucodeLoaded = loaded_r;
endmodule

// File: bench/sysctl_asserts.sv
`include "sysctl_defs.svh"
module sysctl_asserts (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic instrValid,
   input wire logic [15:0] instr,
   input wire logic [1:0] ring,
   input wire logic privIrqEnable,
   input wire logic identAck,
   input wire logic [8:0] identCode,
   input wire logic instrReady,
   input wire logic [15:0] accOut,
   input wire logic accWe,
   input wire sysctl_pkg::level_t currentLevel,
   input wire logic irqSystemOn,
   input wire logic pagingOn,
   input wire logic wideAddressing,
   input wire logic runLamp,
   input wire logic identReq,
   input wire sysctl_pkg::level_t identLevel,
   input wire logic intIrq,
   input wire sysctl_pkg::cause_t intIrqCause
);
   timeunit 1ns;
   timeprecision 1ns;
   import sysctl_pkg::*;
   wire priv = !pagingOn || ring >= `RING_PRIV_LO;
   wire take = instrValid && instrReady;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   a_ion_lamp:
   assert property (take && priv && instr == `OP_IRQ_ON |=> irqSystemOn)
      else $error("Interrupt on did not light the lamp.");
   // The level may only move while switching is enabled.
   a_iof_freeze:
   assert property (!irqSystemOn && $past(!irqSystemOn) |->
      $stable(currentLevel)) else $error("Level moved while off.");
   a_ident_level:
   assert property (identReq |-> identLevel >= `LVL_IDENT10 &&
      identLevel <= `LVL_IDENT13) else $error("Identify level bad.");
   a_ident_code:
   assert property (identReq && identAck |=> accWe &&
      accOut == {`IDENT_PAD, $past(identCode)})
      else $error("Identify code not placed in A.");
   a_ident_bound:
   assert property ($rose(identReq) |-> ##[1:18] !identReq)
      else $error("Identify never gave up.");
   a_wide_set:
   assert property (take && priv && instr == `OP_WIDE_SET |->
      ##[1:2] wideAddressing) else $error("Wide mode not set.");
   a_wide_clr:
   assert property (take && priv && instr == `OP_WIDE_CLR |->
      ##[1:2] !wideAddressing) else $error("Wide mode not cleared.");
   a_priv_refuse:
   assert property (take && !priv && privIrqEnable &&
      instr == `OP_IRQ_OFF |=> intIrq && intIrqCause == `CAUSE_PRIV &&
      $stable(irqSystemOn)) else $error("Privileged op not refused.");
   c_ident_hit: cover property (identReq && identAck);
   c_halt: cover property (!runLamp);
   c_priv: cover property (intIrq && intIrqCause == `CAUSE_PRIV);
endmodule
bind system_control_instruction_unit sysctl_asserts u_chk (.*);

// File: bench/io_device_model.sv
`include "sysctl_defs.svh"
module io_device_model (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic [15:0] raise,
   input wire logic slow,
   input wire logic identReq,
   input wire sysctl_pkg::level_t identLevel,
   input wire logic memReq,
   input wire logic [23:0] memAddr,
   output logic [15:0] extReq,
   output logic identAck,
   output logic [8:0] identCode,
   output logic memAck,
   output logic [15:0] memRdata
);
   timeunit 1ns;
   timeprecision 1ns;
   import sysctl_pkg::*;
   localparam logic [15:0] ExtLevels = `EXT_REQ_LEVELS;
   logic [1:0] pend [16];
   logic served;
   int idCnt;
   int memCnt;
   // A wait of three or more keeps a held request from a second answer.
   wire [3:0] dly = slow ? 4'h6 : 4'h3;
   initial begin
      identAck = 1'b0;
      memAck = 1'b0;
      identCode = 9'h000;
      memRdata = 16'h0000;
      served = 1'b0;
      for (int i = 0; i < 16; i++) pend[i] = 2'h0;
   end
   always_comb for (int i = 0; i < 16; i++) extReq[i] = pend[i] != 2'h0;
   always @(posedge sys_clk) begin
      identAck <= 1'b0;
      memAck <= 1'b0;
      identCode <= ~identCode;
      memRdata <= ~memRdata;
      idCnt <= identReq && !served ? idCnt + 1 : 0;
      memCnt <= memReq ? memCnt + 1 : 0;
      if (!identReq) served <= 1'b0;
      for (int i = 0; i < 16; i++) begin
         if (raise[i] && ExtLevels[i]) pend[i] <= pend[i] + 2'h1;
      end
      if (idCnt == dly && pend[identLevel] != 2'h0) begin
         identAck <= 1'b1;
         identCode <= {identLevel, pend[identLevel][1], 4'h5};
         pend[identLevel] <= pend[identLevel] - 2'h1;
         served <= 1'b1;
      end
      if (memCnt == dly) begin
         memAck <= 1'b1;
         memRdata <= memAddr[15:0] ^ 16'h5A5A;
         memCnt <= 0;
      end
      if (!resetn) begin
         for (int i = 0; i < 16; i++) pend[i] <= 2'h0;
         served <= 1'b0;
      end
   end
endmodule

// File: bench/testbench.sv
`include "sysctl_defs.svh"
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import sysctl_pkg::*;
   logic sys_clk = 0, resetn = 0, instrValid = 0, consoleRestart = 0;
   logic ioErrIrqEnable = 1, privIrqEnable = 1, slow = 0;
   logic [15:0] instr = 0, aIn = 0, dIn = 0, tIn = 0, raise = 0;
   logic [1:0] ring = 2'h3;
   wire instrReady, instrDone, accWe, tWe, irqSystemOn, pagingOn, memAck;
   wire wideAddressing, runLamp, identReq, memReq, memWe, intIrq;
   wire ucodeLoaded, identAck;
   wire [15:0] accOut, tOut, memWdata, memRdata, extReq;
   wire [23:0] memAddr;
   wire [8:0] identCode;
   level_t currentLevel, identLevel;
   cause_t intIrqCause;
   int num_errors = 0, samples_checked = 0;
   system_control_instruction_unit u_dut (.*);
   io_device_model u_dev (.*);
   initial forever #20 sys_clk = ~sys_clk;
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic complete_run;
      $display("Checks %0d, errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // Inputs move on the falling edge so the rising edge sees them settled.
   task automatic exec(input logic [15:0] op, input logic [15:0] a);
      int n;
      @(negedge sys_clk);
      {instr, aIn, dIn, tIn, instrValid} = {op, a, 16'($urandom), 16'($urandom), 1'b1};
      for (n = 0; instrReady !== 1'b1 && n < 50; n++) @(negedge sys_clk);
      if (n >= 50) begin
         num_errors++;
         complete_run;
      end
      @(negedge sys_clk);
      instrValid = 0;
      for (n = 0; instrDone !== 1'b1 && n < 9000; n++) @(negedge sys_clk);
      if (n >= 9000) begin
         num_errors++;
         complete_run;
      end
      @(negedge sys_clk);
   endtask
   task automatic rd(input logic [3:0] code, input logic [15:0] exp);
      exec(`OP_RD_REG | 16'(code), 16'h0000);
      check(accOut, exp);
   endtask
   function automatic level_t highest(input logic [15:0] m);
      highest = `LVL_ZERO;
      for (int i = 0; i < 16; i++) if (m[i]) highest = 4'(i);
   endfunction
   function automatic logic [15:0] devId(input int l, input logic k);
      return {`IDENT_PAD, 4'(l), k, 4'h5};
   endfunction
   initial begin
      logic [15:0] e, m, r;
      logic [15:0] idop [4];
      idop = '{`OP_IDENT10, `OP_IDENT11, `OP_IDENT12, `OP_IDENT13};
      e = $urandom(32'hF1E2CCAA);
      repeat (3) @(posedge sys_clk);
      @(negedge sys_clk);
      resetn = 1;
      check({runLamp, irqSystemOn, currentLevel}, 16'h0020);
      rd(`REG_EN_MASK, 16'h0000);
      rd(`REG_REQ_MASK, 16'h0000);
      repeat (4) begin
         {e, m, r} = {16'($urandom), 16'($urandom), 16'($urandom)};
         exec(`OP_WR_REG | `REG_EN_MASK, e);
         exec(`OP_MCLR | `REG_EN_MASK, m);
         rd(`REG_EN_MASK, e & ~m);
         exec(`OP_MSET | `REG_EN_MASK, m);
         rd(`REG_EN_MASK, e | m);
         exec(`OP_WR_REG | `REG_REQ_MASK, r);
         rd(`REG_REQ_MASK, r);
         exec(`OP_IRQ_ON, 0);
         check(currentLevel, highest((e | m) & r));
         exec(`OP_IRQ_OFF, 0);
         exec(`OP_WR_REG | `REG_REQ_MASK, 0);
         check(currentLevel, highest((e | m) & r));
      end
      exec(`OP_WR_REG | `REG_EN_MASK, 16'hFFFF);
      exec(`OP_WR_REG | `REG_REQ_MASK, 16'h0220);
      exec(`OP_IRQ_ON, 0);
      check(currentLevel, 4'h9);
      exec(`OP_WAIT, 0);
      check(currentLevel, 4'h5);
      rd(`REG_REQ_MASK, 16'h0020);
      exec(`OP_WAIT, 0);
      check(currentLevel, `LVL_ZERO);
      exec(`OP_WAIT, 0);
      check({runLamp, currentLevel}, 16'h0010);
      exec(`OP_IRQ_OFF, 0);
      for (int i = 0; i < 4; i++) begin
         slow = i[0];
         exec(`OP_WR_REG | `REG_REQ_MASK, 0);
         repeat (2) begin
            @(negedge sys_clk) raise = 16'h0400 << i;
            @(negedge sys_clk) raise = 16'h0000;
         end
         @(negedge sys_clk);
         rd(`REG_REQ_MASK, 16'h0400 << i);
         exec(idop[i], 0);
         check(accOut, devId(10 + i, 1'b1));
         exec(idop[i], 16'hFFFF);
         check(accOut, devId(10 + i, 1'b0));
         check(extReq[10 + i], 1'b0);
         exec(idop[i], 0);
         check(accOut, devId(10 + i, 1'b0));
         check(intIrqCause, `CAUSE_IO);
      end
      exec(`OP_WIDE_SET, 0);
      check(wideAddressing, 1'b1);
      exec(`OP_WIDE_CLR, 0);
      check(wideAddressing, 1'b0);
      exec(`OP_PAGE_IRQ_ON, 0);
      check({pagingOn, irqSystemOn}, 16'h0003);
      ring = 2'h0;
      exec(`OP_IRQ_OFF, 0);
      check({irqSystemOn, intIrqCause}, 16'h0005);
      exec(`OP_PAGE_OFF, 0);
      check(pagingOn, 1'b1);
      ring = 2'h2;
      exec(`OP_RD_REG | `REG_REQ_MASK, 0);
      check(accOut[14], 1'b1);
      exec(`OP_PAGE_IRQ_OFF, 0);
      check({pagingOn, irqSystemOn}, 16'h0000);
      exec(`OP_PAGE_ON, 0);
      ring = 2'h3;
      exec(`OP_PAGE_OFF, 0);
      check(pagingOn, 1'b0);
      slow = 1;
      exec(`OP_PEEK, 16'($urandom));
      check(tOut, dIn ^ 16'h5A5A);
      check(memWe, 1'b0);
      exec(`OP_POKE, 16'($urandom));
      check(memWdata, tIn);
      check({memWe, memReq}, 16'h0002);
      slow = 0;
      exec(`OP_UCODE_LOAD, 0);
      check(ucodeLoaded, 1'b1);
      // The address has stepped once past the last word of the image.
      check(memAddr[15:0], 16'h4000);
      fork
         exec(`OP_WAIT, 0);
         begin
            repeat (8) @(negedge sys_clk);
            check(runLamp, 1'b0);
            consoleRestart = 1;
            @(negedge sys_clk) consoleRestart = 0;
         end
      join
      check(runLamp, 1'b1);
      complete_run;
   end
endmodule
